//--- include/cscc_pkg.sv
// Purpose: shared constants of the cpu status and core control bank
// Assumes: 32-bit axi4-lite data, 16-bit registers in the low half
// Notes:   offsets are byte addresses of aligned words
package cscc_pkg;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [7:0]  OFF_STATUS    = 8'h00;
  localparam logic [7:0]  OFF_CORE      = 8'h04;
  localparam logic [7:0]  OFF_LEVEL     = 8'h08;
  localparam logic [7:0]  OFF_IRQ_STS   = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_MSK   = 8'h10;
  localparam logic [7:0]  OFF_CORE_BCLR = 8'h14;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int          SR_CARRY      = 0;
  localparam int          SR_ZERO       = 1;
  localparam int          SR_OVF        = 2;
  localparam int          SR_NEG        = 3;
  localparam int          SR_REPEAT     = 4;
  localparam int          SR_LEVEL_LO   = 5;
  localparam int          SR_DIGIT      = 8;
  localparam int          CORE_LVL_MSB  = 3;
  localparam int          CORE_PSV      = 2;
  localparam int          IRQ_TRAP      = 0;
  localparam int          IRQ_OVF       = 1;
  localparam int          IRQ_W         = 2;

  // ***************************************************************
  // masks, reset values, constants
  // ***************************************************************
  localparam logic [15:0] SR_WMASK      = 16'h01EF;
  localparam logic [15:0] SR_ALU_MASK   = 16'h010F;
  localparam logic [15:0] SR_RST        = 16'h0000;
  localparam logic        LVL_MSB_RST   = 1'h0;
  localparam logic        PSV_RST       = 1'h1;
  localparam logic [15:0] PSV_BASE      = 16'h8000;
  localparam logic [3:0]  LEVEL_HI_ADD  = 4'h8;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

//--- include/cscc_if.sv
// Purpose: carrier between the bank and its flag and read-gate units
// Assumes: all signals on core_clk, combinational paths only
// Notes:   flag vectors line up with the status register bits
`timescale 1ns/1ps
`default_nettype none
interface cscc_if;
  logic        alu_sub;
  logic        alu_byte;
  logic        alu_cin;
  logic [15:0] alu_a;
  logic [15:0] alu_b;
  logic [15:0] alu_res;
  logic [8:0]  alu_flags;
  logic        rd_valid;
  logic [15:0] rd_addr;
  logic        psv_en;
  logic        dm_rd;
  logic        pm_rd;
  logic        trap;

  modport alu_mp (input alu_sub, alu_byte, alu_cin, alu_a, alu_b,
                  output alu_res, alu_flags);
  modport gate_mp (input rd_valid, rd_addr, psv_en, output dm_rd, pm_rd, trap);
  modport top_mp (output alu_sub, alu_byte, alu_cin, alu_a, alu_b, rd_valid,
                  rd_addr, psv_en, input alu_res, alu_flags, dm_rd, pm_rd, trap);
endinterface
`default_nettype wire

//--- hw/cscc_alu_flags.sv
// Purpose: add/subtract with status flag generation
// Assumes: subtract is a + ~b + cin, cin one for plain subtract
// Notes:   carry and digit carry read one when no borrow occurred
`timescale 1ns/1ps
`default_nettype none
module cscc_alu_flags (
  cscc_if.alu_mp ifc
);
  logic [15:0] b_eff;
  logic [16:0] sum_w;
  logic [8:0]  sum_b;
  logic [8:0]  half_w;
  logic [4:0]  half_b;
  logic        sign_a;
  logic        sign_b;
  logic        sign_r;

  // ***************************************************************
  // arithmetic
  // ***************************************************************
  always_comb
  begin
    b_eff  = ifc.alu_sub ? ~ifc.alu_b : ifc.alu_b;
    sum_w  = {1'h0, ifc.alu_a} + {1'h0, b_eff} + {16'h0000, ifc.alu_cin};
    sum_b  = {1'h0, ifc.alu_a[7:0]} + {1'h0, b_eff[7:0]} + {8'h00, ifc.alu_cin};
    half_w = {1'h0, ifc.alu_a[7:0]} + {1'h0, b_eff[7:0]} + {8'h00, ifc.alu_cin};
    half_b = {1'h0, ifc.alu_a[3:0]} + {1'h0, b_eff[3:0]} + {4'h0, ifc.alu_cin};
    ifc.alu_res = ifc.alu_byte ? {8'h00, sum_b[7:0]} : sum_w[15:0];
    sign_a = ifc.alu_byte ? ifc.alu_a[7] : ifc.alu_a[15];
    sign_b = ifc.alu_byte ? b_eff[7] : b_eff[15];
    sign_r = ifc.alu_byte ? sum_b[7] : sum_w[15];
    ifc.alu_flags = 9'h000;
    ifc.alu_flags[cscc_pkg::SR_CARRY] = ifc.alu_byte ? sum_b[8] : sum_w[16];
    ifc.alu_flags[cscc_pkg::SR_DIGIT] = ifc.alu_byte ? half_b[4] : half_w[8];
    ifc.alu_flags[cscc_pkg::SR_ZERO]  = (ifc.alu_res == 16'h0000);
    ifc.alu_flags[cscc_pkg::SR_NEG]   = sign_r;
    ifc.alu_flags[cscc_pkg::SR_OVF]   = (sign_a == sign_b) && (sign_r != sign_a);
  end
endmodule
`default_nettype wire

//--- hw/cscc_psv_gate.sv
// Purpose: steers data reads to data memory, program window or trap
// Assumes: request and window enable on the same clock
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module cscc_psv_gate (
  cscc_if.gate_mp ifc
);
  logic hi;

  always_comb
  begin
    hi         = (ifc.rd_addr >= cscc_pkg::PSV_BASE);
    ifc.dm_rd  = ifc.rd_valid & ~hi;
    ifc.pm_rd  = ifc.rd_valid & hi & ifc.psv_en;
    ifc.trap   = ifc.rd_valid & hi & ~ifc.psv_en;
  end
endmodule
`default_nettype wire

//--- hw/cscc_top.sv
// Purpose: cpu status flags, core control and priority level bank
// Assumes: core-side inputs come from logic on core_clk
// Notes:   axi4-lite slave, one write and one read in flight
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cscc_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              alu_valid,
  input  wire logic              alu_sub,
  input  wire logic              alu_byte,
  input  wire logic              alu_carry_in,
  input  wire logic [15:0]       alu_a,
  input  wire logic [15:0]       alu_b,
  input  wire logic [8:0]        alu_flag_mask,
  output logic [15:0]            alu_result,
  input  wire logic              repeat_active,
  input  wire logic              priority_level_msb_set,
  input  wire logic              dread_valid,
  input  wire logic [15:0]       dread_addr,
  output logic                   dm_read_en,
  output logic                   pm_read_en,
  output logic                   addr_trap,
  output logic [3:0]             cpu_priority_level,
  output logic                   irq
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [15:0]              sr;
    logic                     lvl_msb;
    logic                     psv;
    logic [1:0]               ists;
    logic [1:0]               imsk;
    logic                     aw_got;
    logic                     w_got;
    logic [ADDR_W-1:0]        awaddr;
    logic [15:0]              wdata;
    logic [1:0]               wstrb;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
    logic [15:0]              alu_res;
    logic                     trap;
  } cscc_state_t;

  cscc_state_t s_q;
  cscc_state_t s_d;

  cscc_if ifc ();

  logic [15:0]       wmask;
  logic [7:0]        waddr_w;
  logic [7:0]        raddr_w;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              commit;
  logic [15:0]       alu_m;
  logic [1:0]        events;
  logic [32:0]       rd_w;

  // ***************************************************************
  // sub units
  // ***************************************************************
  cscc_alu_flags u_alu (
    .ifc (ifc.alu_mp)
  );

  cscc_psv_gate u_gate (
    .ifc (ifc.gate_mp)
  );

  assign ifc.alu_sub  = alu_sub;
  assign ifc.alu_byte = alu_byte;
  assign ifc.alu_cin  = alu_carry_in;
  assign ifc.alu_a    = alu_a;
  assign ifc.alu_b    = alu_b;
  assign ifc.rd_valid = dread_valid;
  assign ifc.rd_addr  = dread_addr;
  assign ifc.psv_en   = s_q.psv;

  // ***************************************************************
  // read mux
  // ***************************************************************
  function automatic logic [32:0] rd_mux(input logic [7:0] a, input cscc_state_t s,
                                         input logic ra);
    logic [15:0] v;
    logic        ok;
    v  = 16'h0000;
    ok = 1'h1;
    unique case (a)
      cscc_pkg::OFF_STATUS:
      begin
        v = s.sr;
        v[cscc_pkg::SR_REPEAT] = ra;
      end
      cscc_pkg::OFF_CORE:
      begin
        v[cscc_pkg::CORE_LVL_MSB] = s.lvl_msb;
        v[cscc_pkg::CORE_PSV]     = s.psv;
      end
      cscc_pkg::OFF_LEVEL:     v = {12'h000, s.lvl_msb, s.sr[7:5]};
      cscc_pkg::OFF_IRQ_STS:   v = {14'h0000, s.ists};
      cscc_pkg::OFF_IRQ_MSK:   v = {14'h0000, s.imsk};
      cscc_pkg::OFF_CORE_BCLR: v = 16'h0000;
      default:                 ok = 1'h0;
    endcase
    return {ok, 16'h0000, v};
  endfunction

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    s_d     = s_q;
    aw_hs   = s_axi_awvalid & s_axi_awready;
    w_hs    = s_axi_wvalid & s_axi_wready;
    ar_hs   = s_axi_arvalid & s_axi_arready;
    commit  = s_q.aw_got & s_q.w_got;
    wmask   = {{8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
    waddr_w = {s_q.awaddr[7:2], 2'h0};
    raddr_w = {s_axi_araddr[7:2], 2'h0};
    alu_m   = {7'h00, alu_flag_mask} & cscc_pkg::SR_ALU_MASK;
    events  = 2'h0;
    rd_w    = rd_mux(raddr_w, s_q, repeat_active);

    // address and data taken in either order
    if (aw_hs)
    begin
      s_d.aw_got = 1'h1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (w_hs)
    begin
      s_d.w_got = 1'h1;
      s_d.wdata = s_axi_wdata[15:0];
      s_d.wstrb = s_axi_wstrb[1:0];
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'h0;
    end

    if (commit)
    begin
      s_d.aw_got = 1'h0;
      s_d.w_got  = 1'h0;
      s_d.bvalid = 1'h1;
      s_d.bresp  = cscc_pkg::RESP_OKAY;
      unique case (waddr_w)
        cscc_pkg::OFF_STATUS:
        begin
          s_d.sr = (s_q.sr & ~(wmask & cscc_pkg::SR_WMASK))
                 | (s_q.wdata & wmask & cscc_pkg::SR_WMASK);
        end
        cscc_pkg::OFF_CORE:
        begin
          // write with byte lane 0 enabled is the only path to the window enable
          if (wmask[cscc_pkg::CORE_PSV])
          begin
            s_d.psv = s_q.wdata[cscc_pkg::CORE_PSV];
          end
          if (wmask[cscc_pkg::CORE_LVL_MSB] && !s_q.wdata[cscc_pkg::CORE_LVL_MSB])
          begin
            s_d.lvl_msb = 1'h0;
          end
        end
        cscc_pkg::OFF_CORE_BCLR:
        begin
          // bit-clear alias reaches the level msb only
          if (wmask[cscc_pkg::CORE_LVL_MSB] && s_q.wdata[cscc_pkg::CORE_LVL_MSB])
          begin
            s_d.lvl_msb = 1'h0;
          end
        end
        cscc_pkg::OFF_IRQ_STS:
        begin
          s_d.ists = s_q.ists & ~(s_q.wdata[1:0] & wmask[1:0]);
        end
        cscc_pkg::OFF_IRQ_MSK:
        begin
          if (wmask[0])
          begin
            s_d.imsk = s_q.wdata[1:0];
          end
        end
        cscc_pkg::OFF_LEVEL:
        begin
          s_d.bresp = cscc_pkg::RESP_OKAY;
        end
        default:
        begin
          s_d.bresp = cscc_pkg::RESP_SLVERR;
        end
      endcase
    end

    // read channel answers one cycle after the address
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'h0;
    end
    if (ar_hs)
    begin
      s_d.rvalid = 1'h1;
      s_d.rdata  = rd_w[31:0];
      s_d.rresp  = rd_w[32] ? cscc_pkg::RESP_OKAY : cscc_pkg::RESP_SLVERR;
    end

    // hardware updates win over a software write in the same cycle
    if (alu_valid)
    begin
      s_d.alu_res = ifc.alu_res;
      s_d.sr = (s_d.sr & ~alu_m) | ({7'h00, ifc.alu_flags} & alu_m);
      events[cscc_pkg::IRQ_OVF] = alu_m[cscc_pkg::SR_OVF]
                                & ifc.alu_flags[cscc_pkg::SR_OVF];
    end
    if (priority_level_msb_set)
    begin
      s_d.lvl_msb = 1'h1;
    end
    events[cscc_pkg::IRQ_TRAP] = ifc.trap;
    s_d.trap = ifc.trap;
    s_d.ists = s_d.ists | events;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q         <= '0;
      s_q.sr      <= cscc_pkg::SR_RST;
      s_q.lvl_msb <= cscc_pkg::LVL_MSB_RST;
      s_q.psv     <= cscc_pkg::PSV_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign s_axi_awready      = ~s_q.aw_got & ~s_q.bvalid;
  assign s_axi_wready       = ~s_q.w_got & ~s_q.bvalid;
  assign s_axi_bvalid       = s_q.bvalid;
  assign s_axi_bresp        = s_q.bresp;
  assign s_axi_arready      = ~s_q.rvalid;
  assign s_axi_rvalid       = s_q.rvalid;
  assign s_axi_rdata        = s_q.rdata;
  assign s_axi_rresp        = s_q.rresp;
  assign alu_result         = s_q.alu_res;
  assign dm_read_en         = ifc.dm_rd;
  assign pm_read_en         = ifc.pm_rd;
  assign addr_trap          = s_q.trap;
  assign cpu_priority_level = {s_q.lvl_msb, s_q.sr[7:5]};
  assign irq                = |(s_q.ists & s_q.imsk);

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_wr_taken;
    s_q.aw_got && s_q.w_got;
  endsequence

  sequence s_bclr_write;
    commit && waddr_w == cscc_pkg::OFF_CORE_BCLR;
  endsequence

  a_level_plus_eight: assert property (
    s_q.lvl_msb |-> cpu_priority_level == ({1'h0, s_q.sr[7:5]} + cscc_pkg::LEVEL_HI_ADD))
    else $error("level not low bits plus eight");

  a_level_above_seven: assert property (
    (cpu_priority_level > 4'h7) == s_q.lvl_msb)
    else $error("msb bit disagrees with level");

  a_level_low_bits: assert property (
    cpu_priority_level[2:0] == s_q.sr[7:5])
    else $error("level low bits not from status");

  a_window_read: assert property (
    dread_valid && dread_addr >= cscc_pkg::PSV_BASE && s_q.psv
    |-> pm_read_en && !dm_read_en ##1 !addr_trap)
    else $error("window read not sent to program memory");

  a_trap_on_high: assert property (
    dread_valid && dread_addr >= cscc_pkg::PSV_BASE && !s_q.psv
    |-> !pm_read_en ##1 addr_trap && s_q.ists[cscc_pkg::IRQ_TRAP])
    else $error("high read without window did not trap");

  a_bitop_psv_safe: assert property (
    s_bclr_write |=> $stable(s_q.psv))
    else $error("bit operation changed window enable");

  a_core_reserved: assert property (
    ar_hs && raddr_w == cscc_pkg::OFF_CORE
    |=> s_axi_rdata[31:4] == 28'h0000000 && s_axi_rdata[1:0] == 2'h0)
    else $error("unimplemented core bits read nonzero");

  a_msb_no_sw_set: assert property (
    !s_q.lvl_msb && !priority_level_msb_set |=> !s_q.lvl_msb)
    else $error("level msb set without hardware cause");

  a_sub_borrow: assert property (
    alu_valid && alu_sub && !alu_byte && alu_carry_in && alu_a < alu_b
    && alu_flag_mask[cscc_pkg::SR_CARRY] |=> !s_q.sr[cscc_pkg::SR_CARRY])
    else $error("borrow not shown in carry flag");

  a_zero_flag: assert property (
    alu_valid && alu_flag_mask[cscc_pkg::SR_ZERO]
    |=> s_q.sr[cscc_pkg::SR_ZERO] == (alu_result == 16'h0000))
    else $error("zero flag does not match result");

  a_write_answer: assert property (
    s_wr_taken |=> s_axi_bvalid ##0 !s_axi_awready [*1])
    else $error("write not answered");

  a_irq_level: assert property (
    irq == |(s_q.ists & s_q.imsk))
    else $error("interrupt line disagrees with status");

endmodule
`default_nettype wire

//--- dv/cscc_tb_top.sv
// Purpose: self-checking bench for the status and core control bank
// Assumes: axi4-lite master in the bench, 10 MHz core_clk, no partner
// Notes:   readies sampled at the falling edge, inputs moved at rising
`timescale 1ns/1ps
`default_nettype none
// ***************************************************************
// compare macro
// ***************************************************************
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module cscc_tb_top;
  logic        core_clk, resetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        alu_valid, alu_sub, alu_byte, alu_carry_in;
  logic [15:0] alu_a, alu_b, alu_result, dread_addr;
  logic [8:0]  alu_flag_mask;
  logic        repeat_active, priority_level_msb_set, dread_valid;
  logic        dm_read_en, pm_read_en, addr_trap, irq;
  logic [3:0]  cpu_priority_level;
  int          n_errors;
  int          compares;

  cscc_top #(.ADDR_W(8)) i_dut (
    .core_clk(core_clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .alu_valid(alu_valid), .alu_sub(alu_sub),
    .alu_byte(alu_byte), .alu_carry_in(alu_carry_in), .alu_a(alu_a),
    .alu_b(alu_b), .alu_flag_mask(alu_flag_mask), .alu_result(alu_result),
    .repeat_active(repeat_active),
    .priority_level_msb_set(priority_level_msb_set),
    .dread_valid(dread_valid), .dread_addr(dread_addr),
    .dm_read_en(dm_read_en), .pm_read_en(pm_read_en), .addr_trap(addr_trap),
    .cpu_priority_level(cpu_priority_level), .irq(irq)
  );

  // ***************************************************************
  // bus and helper tasks
  // ***************************************************************
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ta, tw, sa, sw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= 4'h3;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ta && tw))
    begin
      @(negedge core_clk);
      sa = s_axi_awvalid & s_axi_awready;
      sw = s_axi_wvalid & s_axi_wready;
      @(posedge core_clk);
      if (sa) s_axi_awvalid <= 1'b0;
      if (sw) s_axi_wvalid <= 1'b0;
      ta = ta | sa;
      tw = tw | sw;
    end
    do @(negedge core_clk); while (!s_axi_bvalid);
    `CHK(s_axi_bresp, er)
    @(posedge core_clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(negedge core_clk); while (!s_axi_arready);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge core_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge core_clk);
    s_axi_rready <= 1'b0;
  endtask

  // read a mapped word, expect OKAY and the given low half with a zero upper half
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(r, cscc_pkg::RESP_OKAY)
    `CHK(d, {16'h0000, e})
  endtask

  task automatic msb_pulse;
    @(posedge core_clk);
    priority_level_msb_set <= 1'b1;
    @(posedge core_clk);
    priority_level_msb_set <= 1'b0;
    idle(2);
  endtask

  task automatic dread(input logic [15:0] a, input logic edm, epm, etr);
    @(posedge core_clk);
    dread_valid <= 1'b1;
    dread_addr  <= a;
    @(negedge core_clk);
    `CHK(dm_read_en, edm)
    `CHK(pm_read_en, epm)
    @(posedge core_clk);
    dread_valid <= 1'b0;
    @(negedge core_clk);
    `CHK(addr_trap, etr)
    @(negedge core_clk);
    `CHK(addr_trap, 1'b0)
  endtask

  task automatic alu_op(input logic sub, byt, cin, input logic [15:0] a, b, res, sts);
    @(posedge core_clk);
    alu_valid     <= 1'b1;
    alu_sub       <= sub;
    alu_byte      <= byt;
    alu_carry_in  <= cin;
    alu_a         <= a;
    alu_b         <= b;
    alu_flag_mask <= 9'h10F;
    @(posedge core_clk);
    alu_valid <= 1'b0;
    @(negedge core_clk);
    `CHK(alu_result, res)
    rdc(cscc_pkg::OFF_STATUS, sts);
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset;
    `CHK(cpu_priority_level, 4'h0)
    `CHK(irq, 1'b0)
    rdc(cscc_pkg::OFF_STATUS, 16'h0000);
    rdc(cscc_pkg::OFF_CORE, 16'h0004);
    rdc(cscc_pkg::OFF_LEVEL, 16'h0000);
  endtask

  // set-by-write of msb must be ignored, dead bits stay zero
  task automatic t_core;
    wr(cscc_pkg::OFF_CORE, 16'hFFFF, cscc_pkg::RESP_OKAY);
    rdc(cscc_pkg::OFF_CORE, 16'h0004);
    wr(cscc_pkg::OFF_CORE, 16'h0000, cscc_pkg::RESP_OKAY);
    rdc(cscc_pkg::OFF_CORE, 16'h0000);
    msb_pulse();
    rdc(cscc_pkg::OFF_CORE, 16'h0008);
    wr(cscc_pkg::OFF_CORE_BCLR, 16'h0004, cscc_pkg::RESP_OKAY);
    rdc(cscc_pkg::OFF_CORE, 16'h0008);
    wr(cscc_pkg::OFF_CORE_BCLR, 16'h0008, cscc_pkg::RESP_OKAY);
    rdc(cscc_pkg::OFF_CORE, 16'h0000);
    rdc(cscc_pkg::OFF_CORE_BCLR, 16'h0000);
    wr(cscc_pkg::OFF_CORE, 16'h0004, cscc_pkg::RESP_OKAY);
    msb_pulse();
    wr(cscc_pkg::OFF_CORE, 16'h0004, cscc_pkg::RESP_OKAY);
    rdc(cscc_pkg::OFF_CORE, 16'h0004);
  endtask

  task automatic t_level;
    logic [3:0] lv;
    for (int m = 0; m < 2; m++)
    begin
      if (m == 1) msb_pulse();
      for (int i = 0; i < 8; i++)
      begin
        lv = {m[0], i[2:0]};
        wr(cscc_pkg::OFF_STATUS, {8'h00, i[2:0], 5'h00}, cscc_pkg::RESP_OKAY);
        idle(2);
        `CHK(cpu_priority_level, lv)
        rdc(cscc_pkg::OFF_LEVEL, {12'h000, lv});
        rdc(cscc_pkg::OFF_CORE, {12'h000, lv > 4'h7, 3'h4});
      end
    end
    wr(cscc_pkg::OFF_CORE, 16'h0004, cscc_pkg::RESP_OKAY);
    idle(2);
    `CHK(cpu_priority_level, 4'h7)
  endtask

  // window gating, trap event, mask and write-one-to-clear
  task automatic t_gate;
    dread(16'h7FFE, 1'b1, 1'b0, 1'b0);
    dread(16'h8000, 1'b0, 1'b1, 1'b0);
    rdc(cscc_pkg::OFF_IRQ_STS, 16'h0000);
    wr(cscc_pkg::OFF_CORE, 16'h0000, cscc_pkg::RESP_OKAY);
    dread(16'h8000, 1'b0, 1'b0, 1'b1);
    dread(16'hFFFE, 1'b0, 1'b0, 1'b1);
    dread(16'h7FFE, 1'b1, 1'b0, 1'b0);
    rdc(cscc_pkg::OFF_IRQ_STS, 16'h0001);
    `CHK(irq, 1'b0)
    wr(cscc_pkg::OFF_IRQ_MSK, 16'h0001, cscc_pkg::RESP_OKAY);
    idle(2);
    `CHK(irq, 1'b1)
    wr(cscc_pkg::OFF_IRQ_STS, 16'h0001, cscc_pkg::RESP_OKAY);
    idle(2);
    `CHK(irq, 1'b0)
    rdc(cscc_pkg::OFF_IRQ_STS, 16'h0000);
    wr(cscc_pkg::OFF_CORE, 16'h0004, cscc_pkg::RESP_OKAY);
  endtask

  // borrow sense of carry and digit carry on subtract
  task automatic t_alu;
    wr(cscc_pkg::OFF_STATUS, 16'h0000, cscc_pkg::RESP_OKAY);
    alu_op(1'b1, 1'b0, 1'b1, 16'h0005, 16'h0003, 16'h0002, 16'h0101);
    alu_op(1'b1, 1'b0, 1'b1, 16'h0003, 16'h0005, 16'hFFFE, 16'h0008);
    alu_op(1'b1, 1'b0, 1'b1, 16'h0005, 16'h0005, 16'h0000, 16'h0103);
    alu_op(1'b0, 1'b1, 1'b0, 16'h00FF, 16'h0001, 16'h0000, 16'h0103);
    alu_op(1'b0, 1'b0, 1'b0, 16'h7FFF, 16'h0001, 16'h8000, 16'h010C);
    rdc(cscc_pkg::OFF_IRQ_STS, 16'h0002);
    wr(cscc_pkg::OFF_IRQ_MSK, 16'h0002, cscc_pkg::RESP_OKAY);
    idle(2);
    `CHK(irq, 1'b1)
    wr(cscc_pkg::OFF_IRQ_STS, 16'h0002, cscc_pkg::RESP_OKAY);
    @(posedge core_clk);
    repeat_active <= 1'b1;
    rdc(cscc_pkg::OFF_STATUS, 16'h011C);
    `CHK(irq, 1'b0)
  endtask

  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h18, 16'h1234, cscc_pkg::RESP_SLVERR);
    rd(8'h18, d, r);
    `CHK(r, cscc_pkg::RESP_SLVERR)
    `CHK(d, 32'h00000000)
    wr(cscc_pkg::OFF_STATUS, 16'h00E0, cscc_pkg::RESP_OKAY);
    wr(cscc_pkg::OFF_LEVEL, 16'h000F, cscc_pkg::RESP_OKAY);
    rdc(cscc_pkg::OFF_LEVEL, 16'h0007);
  endtask

  // ***************************************************************
  // run control
  // ***************************************************************
  task automatic test_done;
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // whole run is a few hundred cycles; this is generous
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    test_done();
  end

  initial
  begin
    n_errors = 0;
    compares = 0;
    resetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {alu_valid, alu_sub, alu_byte, alu_carry_in, alu_a, alu_b} = '0;
    alu_flag_mask = 9'h000;
    {repeat_active, priority_level_msb_set, dread_valid, dread_addr} = '0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    t_reset();
    t_core();
    t_level();
    t_gate();
    t_alu();
    t_unmapped();
    test_done();
  end
endmodule
`undef CHK
`default_nettype wire
